// File: iam_addr_match.sv
// What this block does
// [R1] with 7-bit addressing the own address is bits 7 down to 1 of the own-address register.
// [R2] a first byte after a START that matches the own address and whose upper five bits are not 11110b puts the block into slave operation.
// [R3] the address is shifted in most significant bit first, so stored bit 7 meets the first bus bit.
// [R4] a first byte whose upper five bits are 11110b (F0h to F7h) selects 10-bit slave addressing.
// [R5] a matching 10-bit first byte is acknowledged on the bus with no software event raised.
// [R6] reset clears the own-address, extended-address, data and control registers to zero.
// [R7] the direction bit, bit 0, is kept out of the compare and only picks the transfer direction.
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
module iam_addr_match
  import iam_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // i2c pins, open drain
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // slave status
  output logic             slave_mode,
  output logic             ten_bit_sel,
  output logic             xfer_read
);

  // synchronised pins
  logic scl_s;
  logic sda_s;

  iam_sync #(.RST_VAL(1'b1)) u_sync_scl (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .din     (scl_i),
    .dout    (scl_s)
  );

  iam_sync #(.RST_VAL(1'b1)) u_sync_sda (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .din     (sda_i),
    .dout    (sda_s)
  );

  // bus group state
  logic [REG_W-1:0]    own_slave_address_q;
  logic [REG_W-1:0]    own_slave_address_d;
  logic [REG_W-1:0]    extended_own_address_q;
  logic [REG_W-1:0]    extended_own_address_d;
  logic [REG_W-1:0]    data_q;
  logic [REG_W-1:0]    data_d;
  logic [REG_W-1:0]    control_q;
  logic [REG_W-1:0]    control_d;
  logic                wr_pend_q;
  logic                wr_pend_d;
  logic [DEC_BITS-1:0] wr_addr_q;
  logic [DEC_BITS-1:0] wr_addr_d;
  logic [31:0]         hrdata_q;
  logic [31:0]         hrdata_d;
  logic                hreadyout_q;
  logic                hresp_q;

  // i2c group state
  iam_state_t          state_q;
  iam_state_t          state_d;
  logic [REG_W-1:0]    shift_q;
  logic [REG_W-1:0]    shift_d;
  logic [3:0]          bit_cnt_q;
  logic [3:0]          bit_cnt_d;
  logic                scl_p_q;
  logic                scl_p_d;
  logic                sda_p_q;
  logic                sda_p_d;
  logic                sda_oe_q;
  logic                sda_oe_d;
  logic                sda_o_q;
  logic                slave_q;
  logic                slave_d;
  logic                ten_q;
  logic                ten_d;
  logic                read_q;
  logic                read_d;
  logic                addr_load_q;
  logic                addr_load_d;
  logic [REG_W-1:0]    addr_byte_q;
  logic [REG_W-1:0]    addr_byte_d;

  // bus conditions
  logic                acc;
  logic [DEC_BITS-1:0] acc_ofs;
  logic [REG_W-1:0]    status_v;
  logic [REG_W-1:0]    rd_v;

  // bus event detection
  logic                scl_rise;
  logic                scl_fall;
  logic                start_seen;
  logic                stop_seen;
  logic                own_match;
  logic                pfx_match;

  assign acc     = hsel & hready & htrans[HTRANS_ACT];
  assign acc_ofs = haddr[DEC_BITS-1:0];

  always_comb begin
    status_v              = REG_RST;
    status_v[STS_SLAVE]   = slave_q;
    status_v[STS_TEN_BIT] = ten_q;
    status_v[STS_READ]    = read_q;
    status_v[STS_BUSY]    = (state_q != IAM_IDLE);
    status_v[STS_ACKING]  = sda_oe_q;
  end

  always_comb begin
    case (acc_ofs)
      OFS_OWN_ADDR: begin
        rd_v = own_slave_address_q;
      end
      OFS_EXT_ADDR: begin
        rd_v = extended_own_address_q;
      end
      OFS_DATA: begin
        rd_v = data_q;
      end
      OFS_CONTROL: begin
        rd_v = control_q;
      end
      OFS_STATUS: begin
        rd_v = status_v;
      end
      default: begin
        rd_v = REG_RST;
      end
    endcase
  end

  // bus next values: address phase latched, write data taken in data phase
  always_comb begin
    own_slave_address_d    = own_slave_address_q;
    extended_own_address_d = extended_own_address_q;
    data_d                 = data_q;
    control_d              = control_q;
    wr_pend_d              = acc & hwrite;
    wr_addr_d              = acc ? acc_ofs : wr_addr_q;
    hrdata_d               = hrdata_q;
    if (acc && !hwrite) begin
      hrdata_d = {{(32-REG_W){1'b0}}, rd_v};
    end
    if (wr_pend_q) begin
      case (wr_addr_q)
        OFS_OWN_ADDR: begin
          own_slave_address_d = hwdata[REG_W-1:0];
        end
        OFS_EXT_ADDR: begin
          extended_own_address_d = hwdata[REG_W-1:0];
        end
        OFS_DATA: begin
          data_d = hwdata[REG_W-1:0];
        end
        OFS_CONTROL: begin
          control_d = hwdata[REG_W-1:0];
        end
        default: begin
          data_d = data_q;
        end
      endcase
    end
    // hardware load of the received address byte wins over a software write
    if (addr_load_q) begin
      data_d = addr_byte_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      own_slave_address_q    <= REG_RST; // R6
      extended_own_address_q <= REG_RST; // R6
      data_q                 <= REG_RST; // R6
      control_q              <= REG_RST; // R6
      wr_pend_q              <= 1'b0;
      wr_addr_q              <= '0;
      hrdata_q               <= '0;
      hreadyout_q            <= 1'b0;
      hresp_q                <= 1'b0;
    end else begin
      own_slave_address_q    <= own_slave_address_d;
      extended_own_address_q <= extended_own_address_d;
      data_q                 <= data_d;
      control_q              <= control_d;
      wr_pend_q              <= wr_pend_d;
      wr_addr_q              <= wr_addr_d;
      hrdata_q               <= hrdata_d;
      hreadyout_q            <= 1'b1;
      hresp_q                <= 1'b0;
    end
  end

  // line events from the synchronised levels
  assign scl_rise   = scl_s & ~scl_p_q;
  assign scl_fall   = ~scl_s & scl_p_q;
  assign start_seen = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_seen  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // compare ignores the direction bit
  assign own_match = (shift_q[OWN_HI:OWN_LO] == own_slave_address_q[OWN_HI:OWN_LO]); // R1 R7
  assign pfx_match = (shift_q[PFX_HI:PFX_LO] == TEN_BIT_PFX); // R4

  // i2c next values
  always_comb begin
    state_d     = state_q;
    shift_d     = shift_q;
    bit_cnt_d   = bit_cnt_q;
    scl_p_d     = scl_s;
    sda_p_d     = sda_s;
    sda_oe_d    = sda_oe_q;
    slave_d     = slave_q;
    ten_d       = ten_q;
    read_d      = read_q;
    addr_load_d = 1'b0;
    addr_byte_d = addr_byte_q;
    if (!control_q[CTL_ENABLE]) begin
      state_d  = IAM_IDLE;
      sda_oe_d = 1'b0;
      slave_d  = 1'b0;
      ten_d    = 1'b0;
    end else if (start_seen) begin
      state_d   = IAM_ADDR;
      bit_cnt_d = '0;
      sda_oe_d  = 1'b0;
      slave_d   = 1'b0;
      ten_d     = 1'b0;
    end else if (stop_seen) begin
      state_d  = IAM_IDLE;
      sda_oe_d = 1'b0;
      slave_d  = 1'b0;
      ten_d    = 1'b0;
    end else begin
      case (state_q)
        IAM_ADDR: begin
          if (scl_rise) begin
            shift_d   = {shift_q[REG_W-2:0], sda_s}; // R3
            bit_cnt_d = bit_cnt_q + 4'h1;
            if (bit_cnt_q == BYTE_BITS - 4'h1) begin
              state_d = IAM_DECIDE;
            end
          end
        end
        IAM_DECIDE: begin
          if (scl_fall) begin
            addr_load_d = 1'b1;
            addr_byte_d = shift_q;
            read_d      = shift_q[DIR_BIT]; // R7
            ten_d       = pfx_match; // R4
            slave_d     = own_match & ~pfx_match; // R2
            if (own_match && control_q[CTL_ACK]) begin
              sda_oe_d = 1'b1; // R5
              state_d  = IAM_ACK;
            end else begin
              state_d = IAM_IDLE;
            end
          end
        end
        IAM_ACK: begin
          if (scl_fall) begin
            sda_oe_d = 1'b0;
            state_d  = IAM_BUSY;
          end
        end
        IAM_BUSY: begin
          state_d = IAM_BUSY;
        end
        default: begin
          state_d = IAM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q     <= IAM_IDLE;
      shift_q     <= REG_RST;
      bit_cnt_q   <= '0;
      scl_p_q     <= 1'b1;
      sda_p_q     <= 1'b1;
      sda_oe_q    <= 1'b0;
      sda_o_q     <= 1'b0;
      slave_q     <= 1'b0;
      ten_q       <= 1'b0;
      read_q      <= 1'b0;
      addr_load_q <= 1'b0;
      addr_byte_q <= REG_RST;
    end else begin
      state_q     <= state_d;
      shift_q     <= shift_d;
      bit_cnt_q   <= bit_cnt_d;
      scl_p_q     <= scl_p_d;
      sda_p_q     <= sda_p_d;
      sda_oe_q    <= sda_oe_d;
      sda_o_q     <= 1'b0;
      slave_q     <= slave_d;
      ten_q       <= ten_d;
      read_q      <= read_d;
      addr_load_q <= addr_load_d;
      addr_byte_q <= addr_byte_d;
    end
  end

  assign hrdata      = hrdata_q;
  assign hreadyout   = hreadyout_q;
  assign hresp       = hresp_q;
  assign sda_o       = sda_o_q;
  assign sda_oe      = sda_oe_q;
  assign slave_mode  = slave_q;
  assign ten_bit_sel = ten_q;
  assign xfer_read   = read_q;

endmodule

// File: iam_pkg.sv
package iam_pkg;

  // register byte addresses on the bus
  localparam logic [7:0] OFS_OWN_ADDR  = 8'h00;
  localparam logic [7:0] OFS_EXT_ADDR  = 8'h04;
  localparam logic [7:0] OFS_DATA      = 8'h08;
  localparam logic [7:0] OFS_CONTROL   = 8'h0C;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam int         DEC_BITS      = 8;

  // register geometry and reset values
  localparam int         REG_W         = 8;
  localparam logic [7:0] REG_RST       = 8'h00;

  // own-address byte layout
  localparam int         OWN_HI        = 7;
  localparam int         OWN_LO        = 1;
  localparam int         DIR_BIT       = 0;

  // ten-bit prefix in bits 7:3 of the first byte
  localparam int         PFX_HI        = 7;
  localparam int         PFX_LO        = 3;
  localparam logic [4:0] TEN_BIT_PFX   = 5'h1E;

  // control bits
  localparam int         CTL_ENABLE    = 6;
  localparam int         CTL_ACK       = 2;

  // status bits
  localparam int         STS_SLAVE     = 0;
  localparam int         STS_TEN_BIT   = 1;
  localparam int         STS_READ      = 2;
  localparam int         STS_BUSY      = 3;
  localparam int         STS_ACKING    = 4;

  // bits per address byte
  localparam logic [3:0] BYTE_BITS     = 4'h8;

  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam int         HTRANS_ACT    = 1;

  typedef enum logic [2:0] {
    IAM_IDLE,
    IAM_ADDR,
    IAM_DECIDE,
    IAM_ACK,
    IAM_BUSY
  } iam_state_t;

endpackage

// File: iam_sync.sv
module iam_sync
  import iam_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // async level in, synchronised level out
  input  wire logic din,
  output logic      dout
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;

endmodule

// File: iam_sva.sv
module iam_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // pins and flags
  input wire logic scl_i,
  input wire logic sda_oe,
  input wire logic slave_mode,
  input wire logic ten_bit_sel,
  input wire logic xfer_read
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_rst_clear: assert property (disable iff (1'b0) sys_rst |=> !slave_mode && !ten_bit_sel && !sda_oe)
    else $error("flags not cleared by reset");
  a_one_mode: assert property (!(slave_mode && ten_bit_sel))
    else $error("seven and ten bit modes both set");
  a_mode_ack: assert property ($rose(slave_mode) |-> $rose(sda_oe))
    else $error("slave mode entered without ack");
  a_ten_ack: assert property ($rose(ten_bit_sel) |-> sda_oe)
    else $error("ten bit first byte not acked");
  a_ack_len: assert property ($rose(sda_oe) |=> sda_oe [*3])
    else $error("ack pulse too short");
  a_ack_low: assert property ($rose(sda_oe) |-> !scl_i)
    else $error("ack driven while clock high");
  a_dir_hold: assert property ($fell(sda_oe) |-> $stable(xfer_read))
    else $error("direction changed at ack release");

  c_slave: cover property ($rose(slave_mode));
  c_ten: cover property ($rose(ten_bit_sel));
  c_read: cover property ($rose(sda_oe) && xfer_read);
endmodule

bind iam_addr_match iam_sva u_sva (.mclk, .sys_rst, .scl_i, .sda_oe, .slave_mode, .ten_bit_sel, .xfer_read);

// File: iam_i2c_mst.sv
module iam_i2c_mst (
  // clock
  input  wire logic mclk,
  // bus lines
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_m
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hw(input int h);
    repeat (h) @(posedge mclk);
  endtask
  // start, one byte msb first, ack clock; leaves scl low
  task automatic xfer(input logic [7:0] b, input int h, output logic ack);
    sda_m <= 1'b0;
    hw(h);
    for (int i = 7; i >= 0; i--) begin
      scl_o <= 1'b0;
      hw(h / 2);
      sda_m <= b[i];
      hw(h / 2);
      scl_o <= 1'b1;
      hw(h);
    end
    scl_o <= 1'b0;
    hw(h / 2);
    sda_m <= 1'b1;
    hw(h / 2);
    scl_o <= 1'b1;
    hw(h / 2);
    ack = !sda_i;
    hw(h / 2);
    scl_o <= 1'b0;
    hw(h);
  endtask
  task automatic stop(input int h);
    sda_m <= 1'b0;
    hw(h);
    scl_o <= 1'b1;
    hw(h);
    sda_m <= 1'b1;
    hw(h);
  endtask
endmodule

// File: tb_top.sv
`define CHK(n, e, g) begin n_tests++; if ((e) !== (g)) begin n_errors++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_top;
  import iam_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, sys_rst, hsel, hwrite, hreadyout, hresp, rd_ph, ack;
  logic        scl, sda_m, sda_o, sda_oe, slave_mode, ten_bit_sel, xfer_read;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  own;
  logic [31:0] q_e[$], q_m[$];
  int          n_errors, n_tests;
  wire         sda_w = sda_m & ~(sda_oe & ~sda_o);
  localparam logic [7:0] REGS [5] = '{OFS_OWN_ADDR, OFS_EXT_ADDR, OFS_DATA, OFS_CONTROL, 8'h20};

  iam_addr_match u_dut (.mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .scl_i(scl), .sda_i(sda_w), .sda_o,
    .sda_oe, .slave_mode, .ten_bit_sel, .xfer_read);
  iam_i2c_mst u_mst (.mclk, .sda_i(sda_w), .scl_o(scl), .sda_m);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // read results against the oldest note
  always @(posedge mclk) begin
    if (rd_ph === 1'b1 && hreadyout === 1'b1) begin
      `CHK("hrdata", q_e[0], hrdata & q_m[0])
      `CHK("bus resp", 2'h0, {hresp, sda_o})
      void'(q_e.pop_front());
      void'(q_m.pop_front());
    end
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= ~w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    q_e.push_back(e);
    q_m.push_back(m);
    @(posedge mclk);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic rst_chk(input string t);
    sys_rst <= 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    foreach (REGS[i]) rd(REGS[i], 32'h0, 32'hFFFFFFFF);
    $display("test %s done", t);
  endtask
  // one address byte, flags checked mid-transfer, then stop
  task automatic i2c(input logic [7:0] b, input int h, input logic a_e, input logic [2:0] s_e);
    logic [2:0] m;
    m = a_e ? 3'h7 : 3'h3;
    u_mst.xfer(b, h, ack);
    `CHK("ack", a_e, ack)
    `CHK("flags", s_e & m, {xfer_read, ten_bit_sel, slave_mode} & m)
    rd(OFS_STATUS, {29'h0, s_e}, a_e ? 32'h7 : 32'h3);
    if (a_e) rd(OFS_DATA, {24'h0, b}, 32'hFF);
    u_mst.stop(h);
    `CHK("flags", 2'h0, {ten_bit_sel, slave_mode})
    rd(OFS_STATUS, 32'h0, 32'h3);
    $display("test byte %0h done", b);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    {hsel, hwrite, rd_ph, sys_rst} = 4'h1;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'h2;
    void'($urandom(20989));
    rst_chk("reset");
    own = {2'h2, 5'($urandom), 1'b0};
    bus(1'b1, OFS_OWN_ADDR, {24'($urandom), own});
    rd(OFS_OWN_ADDR, {24'h0, own}, 32'hFFFFFFFF);
    bus(1'b1, OFS_EXT_ADDR, 32'h5A);
    rd(OFS_EXT_ADDR, 32'h5A, 32'hFFFFFFFF);
    i2c(own, 8, 1'b0, 3'h0);
    bus(1'b1, OFS_CONTROL, 32'h44);
    i2c(own, 8, 1'b1, 3'h1);
    i2c(own | 8'h01, 8, 1'b1, 3'h5);
    i2c(own ^ 8'h80, 8, 1'b0, 3'h0);
    i2c(own ^ 8'h02, 20, 1'b0, 3'h0);
    own = {TEN_BIT_PFX, 2'($urandom), 1'b0};
    bus(1'b1, OFS_OWN_ADDR, {24'h0, own});
    i2c(own, 8, 1'b1, 3'h2);
    rst_chk("mid reset");
    end_sim;
  end

  initial begin
    repeat (40000) @(posedge mclk);
    n_errors++;
    end_sim;
  end
endmodule
